// File: src/ssp_pkg.sv
// shared constants and types of the synchronous serial port
package ssp_pkg;

	// data path and buffer shape
	localparam int DATA_W      = 16;
	localparam int FIFO_DEPTH  = 8;
	localparam int HALF_DEPTH  = FIFO_DEPTH / 2;

	// frame size field holds bits minus one; smallest frame is four bits
	localparam logic [3:0] SIZE_M1_MIN = 4'h3;
	localparam logic [4:0] BITS_FULL   = 5'h10;

	// command-response framing: control byte plus one turnaround bit
	localparam int         CTRL_BITS     = 8;
	localparam int         CMD_WAIT_BITS = 1;
	localparam logic [4:0] CMD_SKIP      = 5'(CTRL_BITS + CMD_WAIT_BITS);

	// tail of an spi or command frame, in half serial periods
	localparam logic [1:0] TAIL_HALVES = 2'h2;

	// receive timeout, in serial bit periods, and as divider half-period ticks
	localparam int TIMEOUT_BIT_PERIODS = 32;
	localparam int TIMEOUT_TICKS       = 2 * TIMEOUT_BIT_PERIODS;

	// frame formats
	typedef enum logic [1:0] {
		FMT_SPI   = 2'h0,
		FMT_PULSE = 2'h1,
		FMT_CMD   = 2'h2
	} ssp_fmt_t;

	// master sequencer, gray coded along idle-lead-shift-tail
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_LEAD  = 2'b01,
		ST_SHIFT = 2'b11,
		ST_TAIL  = 2'b10
	} ssp_state_t;

	// static configuration
	typedef struct packed {
		logic       enable;
		logic       master;
		ssp_fmt_t   fmt;
		logic [3:0] size_m1;
		logic       clock_polarity;
		logic       clock_phase;
	} ssp_cfg_t;

	// one bit per interrupt source
	typedef struct packed {
		logic overrun;
		logic timeout;
		logic rx_service;
		logic tx_service;
	} ssp_irq_t;

endpackage

// File: src/ssp_fifo.sv
// eight by sixteen first-in first-out buffer with a view of the slot about to be overwritten
`timescale 1ns/1ps
module ssp_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic                     clk_sys_i,
	input  wire logic                     rst_i,
	// fill side
	input  wire logic                     push_i,
	input  wire logic [WIDTH-1:0]         push_data_i,
	// drain side
	input  wire logic                     pop_i,
	output logic      [WIDTH-1:0]         head_o,
	// word written DEPTH writes ago, zero until that many writes happened
	output logic      [WIDTH-1:0]         aged_o,
	// fill state
	output logic                          full_o,
	output logic                          empty_o,
	output logic      [$clog2(DEPTH):0]   count_o
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wptr_q;
	logic [AW-1:0]    rptr_q;
	logic [AW:0]      cnt_q;
	logic             do_push;
	logic             do_pop;

	// refused requests leave the buffer untouched; depth must be a power of two
	assign do_push = push_i & ~full_o;
	assign do_pop  = pop_i & ~empty_o;

	// storage is cleared at reset so that the aged view starts at zero
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
		end else if (do_push) begin
			mem_q[wptr_q] <= push_data_i;
		end
	end

	// pointers and fill count
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			wptr_q <= '0;
			rptr_q <= '0;
			cnt_q  <= '0;
		end else begin
			if (do_push) begin
				wptr_q <= wptr_q + 1'b1;
			end
			if (do_pop) begin
				rptr_q <= rptr_q + 1'b1;
			end
			if (do_push & ~do_pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (do_pop & ~do_push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end

	assign head_o  = mem_q[rptr_q];
	assign aged_o  = mem_q[wptr_q];
	assign full_o  = (cnt_q == (AW+1)'(DEPTH));
	assign empty_o = (cnt_q == '0);
	assign count_o = cnt_q;

endmodule

// File: src/ssp_clkdiv.sv
// two-stage serial clock divider giving one enable pulse per half serial period
`timescale 1ns/1ps
module ssp_clkdiv (
	// clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	// divider setup
	input  wire logic       run_i,
	input  wire logic [7:0] prescale_divisor_i,
	input  wire logic [7:0] serial_clock_rate_i,
	// half-period enable
	output logic            tick_o
);

	logic [6:0] pre_cnt_q;
	logic [6:0] pre_last;
	logic [7:0] rate_cnt_q;

	// even prescale: half of it per half period, bit zero ignored, at least two
	assign pre_last = (prescale_divisor_i[7:1] == 7'h0) ? 7'h0
		: prescale_divisor_i[7:1] - 7'h1;

	// first stage gates the second; the second divides by one plus the rate field
	always_ff @(posedge clk_sys_i) begin
		if (rst_i | ~run_i) begin
			pre_cnt_q  <= '0;
			rate_cnt_q <= '0;
			tick_o     <= 1'b0;
		end else begin
			tick_o <= 1'b0;
			if (pre_cnt_q == pre_last) begin
				pre_cnt_q <= '0;
				if (rate_cnt_q == serial_clock_rate_i) begin
					rate_cnt_q <= '0;
					tick_o     <= 1'b1;
				end else begin
					rate_cnt_q <= rate_cnt_q + 8'h01;
				end
			end else begin
				pre_cnt_q <= pre_cnt_q + 7'h01;
			end
		end
	end

endmodule

// File: src/ssp_sync_serial_port.sv
// synchronous serial port: fifos, frame sequencer, slave front end and interrupt status
// Functional notes
// - separate eight-deep sixteen-bit transmit and receive fifos, first in first out
// - frame length programmable from four to sixteen bits
// - first divider stage divides system clock by even prescale two to 254
// - second stage divides further by one plus the rate field, 1 to 256
// - slave sends on every transfer; empty fifo resends word written eight writes ago
// - slave with empty fifo sends zero until eight words have been written
// - transmit fifo empty raises interrupt or dma request
// - data write pushes transmit fifo; data read pops receive fifo
// - four conditions: tx service, rx service, rx timeout, rx overrun
// - enabled conditions are ored onto one interrupt output
// - each source has a mask bit; one enables it
// - raw and masked status of every source are readable
// - frames go out most significant bit first
// - three formats: frame pulse, spi, half-duplex command-response
// - serial clock parked inactive when idle, toggles only during a frame
// - timeout flagged when rx fifo holds data after serial clock idle period
// - spi and command formats hold frame select low for the whole frame
// - frame pulse format raises frame line one period before each frame
// - frame pulse format drives data on rising, samples on falling edge
// - command format sends eight control bits first, ignoring input meanwhile
// - spi polarity low parks clock low, high parks it high
// - spi phase low captures on first edge, high on second edge
// - frame pulse format idles clock and frame low, transmit line tristated
`timescale 1ns/1ps
module ssp_sync_serial_port #(
	parameter int DATA_W     = ssp_pkg::DATA_W,
	parameter int FIFO_DEPTH = ssp_pkg::FIFO_DEPTH
) (
	// clock and reset
	input  wire logic                   clk_sys_i,
	input  wire logic                   rst_i,
	// configuration
	input  wire ssp_pkg::ssp_cfg_t      cfg_i,
	input  wire logic [7:0]             prescale_divisor_i,
	input  wire logic [7:0]             serial_clock_rate_i,
	input  wire ssp_pkg::ssp_irq_t      irq_mask_i,
	input  wire ssp_pkg::ssp_irq_t      irq_clear_i,
	// data register
	input  wire logic                   data_wr_i,
	input  wire logic [DATA_W-1:0]      data_wr_data_i,
	input  wire logic                   data_rd_i,
	output logic      [DATA_W-1:0]      data_rd_data_o,
	// status and requests
	output ssp_pkg::ssp_irq_t           raw_irq_o,
	output ssp_pkg::ssp_irq_t           masked_irq_o,
	output logic                        irq_o,
	output logic                        tx_dma_req_o,
	output logic                        busy_o,
	// serial pins
	input  wire logic                   serial_clock_pin_i,
	output logic                        serial_clock_pin_o,
	output logic                        serial_clock_pin_oe_o,
	input  wire logic                   frame_select_pin_i,
	output logic                        frame_select_pin_o,
	output logic                        frame_select_pin_oe_o,
	input  wire logic                   serial_in_pin_i,
	output logic                        serial_out_pin_o,
	output logic                        serial_out_pin_oe_o
);

	localparam int CW = $clog2(FIFO_DEPTH) + 1;

	ssp_pkg::ssp_state_t state_q;
	logic [1:0]          half_cnt_q;
	logic                sclk_q;
	logic                fss_q;
	logic [DATA_W-1:0]   tx_sh_q;
	logic [DATA_W-1:0]   rx_sh_q;
	logic [4:0]          cap_cnt_q;
	logic                slv_act_q;
	logic [6:0]          to_cnt_q;
	logic                ovr_q;
	logic                to_q;
	// pin synchronisers
	logic                sclk_s1_q, sclk_s2_q, sclk_s3_q;
	logic                fss_s1_q, fss_s2_q, fss_s3_q;
	logic                sin_s1_q, sin_s2_q;

	// fifo and divider hookup
	logic [DATA_W-1:0]   tx_head, tx_aged, rx_head;
	logic                tx_full, tx_empty, rx_full, rx_empty;
	logic [CW-1:0]       tx_count, rx_count;
	logic                tx_pop, rx_push, rx_pop, tick;

	// decoded configuration
	logic                master, slave, is_pulse, is_cmd, pol_eff, pha_eff;
	logic [3:0]          size_m1;
	logic [4:0]          word_bits, frame_bits;
	logic [DATA_W-1:0]   word_mask, tx_load, tx_word;
	logic                m_start, m_edge, s_rise, s_fall, s_fss_rise, s_fss_fall;
	logic                s_active, s_edge, ser_edge, lead, cap_ev, launch_ev;
	logic                word_done, slv_load;
	logic [4:0]          cap_cnt_d;
	logic [DATA_W-1:0]   rx_sh_d;
	ssp_pkg::ssp_irq_t   raw_c;

	// both buffers, eight by sixteen
	ssp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
		.clk_sys_i   (clk_sys_i),
		.rst_i       (rst_i),
		.push_i      (data_wr_i),
		.push_data_i (data_wr_data_i),
		.pop_i       (tx_pop),
		.head_o      (tx_head),
		.aged_o      (tx_aged),
		.full_o      (tx_full),
		.empty_o     (tx_empty),
		.count_o     (tx_count)
	);

	ssp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.clk_sys_i   (clk_sys_i),
		.rst_i       (rst_i),
		.push_i      (rx_push),
		.push_data_i (rx_sh_d & word_mask),
		.pop_i       (rx_pop),
		.head_o      (rx_head),
		.aged_o      (),
		.full_o      (rx_full),
		.empty_o     (rx_empty),
		.count_o     (rx_count)
	);

	ssp_clkdiv u_clkdiv (
		.clk_sys_i           (clk_sys_i),
		.rst_i               (rst_i),
		.run_i               (cfg_i.enable),
		.prescale_divisor_i  (prescale_divisor_i),
		.serial_clock_rate_i (serial_clock_rate_i),
		.tick_o              (tick)
	);

	// configuration decode; frame pulse and command formats use fixed edges
	assign master     = cfg_i.enable & cfg_i.master;
	assign slave      = cfg_i.enable & ~cfg_i.master;
	assign is_pulse   = (cfg_i.fmt == ssp_pkg::FMT_PULSE);
	assign is_cmd     = (cfg_i.fmt == ssp_pkg::FMT_CMD);
	assign pol_eff    = (cfg_i.fmt == ssp_pkg::FMT_SPI) & cfg_i.clock_polarity;
	assign pha_eff    = is_pulse | ((cfg_i.fmt == ssp_pkg::FMT_SPI) & cfg_i.clock_phase);
	assign size_m1    = (cfg_i.size_m1 < ssp_pkg::SIZE_M1_MIN) ? ssp_pkg::SIZE_M1_MIN
		: cfg_i.size_m1;
	assign word_bits  = {1'b0, size_m1} + 5'h01;
	assign frame_bits = is_cmd & master ? word_bits + ssp_pkg::CMD_SKIP : word_bits;
	assign word_mask  = {DATA_W{1'b1}} >> (ssp_pkg::BITS_FULL - word_bits);

	// slave reuses the aged slot when software fell behind
	assign tx_word = (slave & tx_empty) ? tx_aged : tx_head;
	// left align so the top bit leaves first; command sends only its control byte
	assign tx_load = is_cmd & master
		? {tx_word[ssp_pkg::CTRL_BITS-1:0], {(DATA_W-ssp_pkg::CTRL_BITS){1'b0}}}
		: DATA_W'(tx_word << (ssp_pkg::BITS_FULL - word_bits));

	// pin edge detection looks only at the second and third synchroniser stages
	assign s_rise     = sclk_s2_q & ~sclk_s3_q;
	assign s_fall     = ~sclk_s2_q & sclk_s3_q;
	assign s_fss_rise = fss_s2_q & ~fss_s3_q;
	assign s_fss_fall = ~fss_s2_q & fss_s3_q;
	assign s_active   = slave & (is_pulse ? slv_act_q : ~fss_s2_q);

	// one edge event from whichever side owns the serial clock
	assign m_start   = master & (state_q == ssp_pkg::ST_IDLE) & ~tx_empty;
	assign m_edge    = master & (state_q == ssp_pkg::ST_SHIFT) & tick;
	assign s_edge    = s_active & (s_rise | s_fall);
	assign ser_edge  = m_edge | s_edge;
	assign lead      = master ? (sclk_q == pol_eff) : (pol_eff ? s_fall : s_rise);
	assign cap_ev    = ser_edge & (lead ^ pha_eff);
	assign launch_ev = ser_edge & ~(lead ^ pha_eff) & (cap_cnt_q != 5'h00);
	assign cap_cnt_d = cap_cnt_q + 5'h01;
	assign word_done = cap_ev & (cap_cnt_d == frame_bits);

	// control byte and turnaround bit are not shifted into the receive word
	assign rx_sh_d = (is_cmd & master & (cap_cnt_q < ssp_pkg::CMD_SKIP)) ? rx_sh_q
		: {rx_sh_q[DATA_W-2:0], sin_s2_q};

	// a full receive fifo refuses the word, which is then lost
	assign rx_push  = word_done;
	assign rx_pop   = data_rd_i & ~rx_empty;
	assign slv_load = slave & ((is_pulse ? s_fss_rise : s_fss_fall)
		| (word_done & ~is_pulse & ~fss_s2_q));
	assign tx_pop   = m_start | (slv_load & ~tx_empty);

	// input synchronisers for every pin that enters from outside: three stages for clock and frame select, two for serial data in
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			sclk_s1_q <= 1'b0;
			sclk_s2_q <= 1'b0;
			sclk_s3_q <= 1'b0;
			fss_s1_q  <= 1'b1;
			fss_s2_q  <= 1'b1;
			fss_s3_q  <= 1'b1;
			sin_s1_q  <= 1'b0;
			sin_s2_q  <= 1'b0;
		end else begin
			sclk_s1_q <= serial_clock_pin_i;
			sclk_s2_q <= sclk_s1_q;
			sclk_s3_q <= sclk_s2_q;
			fss_s1_q  <= frame_select_pin_i;
			fss_s2_q  <= fss_s1_q;
			fss_s3_q  <= fss_s2_q;
			sin_s1_q  <= serial_in_pin_i;
			sin_s2_q  <= sin_s1_q;
		end
	end

	// master sequencer: serial clock and frame line
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			state_q    <= ssp_pkg::ST_IDLE;
			half_cnt_q <= 2'h0;
			sclk_q     <= 1'b0;
			fss_q      <= 1'b1;
		end else if (~master) begin
			state_q    <= ssp_pkg::ST_IDLE;
			half_cnt_q <= 2'h0;
			sclk_q     <= pol_eff;
			fss_q      <= ~is_pulse;
		end else begin
			unique case (state_q)
				ssp_pkg::ST_IDLE: begin
					sclk_q <= pol_eff;
					fss_q  <= ~is_pulse;
					if (m_start) begin
						state_q <= ssp_pkg::ST_LEAD;
						// pulse format opens its frame pulse on a rising edge
						sclk_q  <= is_pulse;
						fss_q   <= is_pulse;
					end
				end
				ssp_pkg::ST_LEAD: begin
					if (tick) begin
						state_q <= ssp_pkg::ST_SHIFT;
						if (is_pulse) begin
							sclk_q <= 1'b0;
						end
					end
				end
				ssp_pkg::ST_SHIFT: begin
					if (tick) begin
						sclk_q <= ~sclk_q;
						// frame pulse drops one full period after it rose
						if (is_pulse) begin
							fss_q <= 1'b0;
						end
						if ((cap_cnt_q == frame_bits) & (~sclk_q == pol_eff)) begin
							state_q    <= is_pulse ? ssp_pkg::ST_IDLE : ssp_pkg::ST_TAIL;
							half_cnt_q <= 2'h0;
						end
					end
				end
				ssp_pkg::ST_TAIL: begin
					// select stays low one serial period after the clock returns to its idle level
					if (tick) begin
						half_cnt_q <= half_cnt_q + 2'h1;
						if (half_cnt_q == ssp_pkg::TAIL_HALVES - 2'h1) begin
							state_q <= ssp_pkg::ST_IDLE;
							fss_q   <= 1'b1;
						end
					end
				end
			endcase
		end
	end

	// shift registers and bit counter shared by master and slave
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			tx_sh_q   <= '0;
			rx_sh_q   <= '0;
			cap_cnt_q <= 5'h00;
		end else if (m_start | slv_load) begin
			tx_sh_q   <= tx_load;
			cap_cnt_q <= 5'h00;
		end else if (slave & ~s_active) begin
			cap_cnt_q <= 5'h00;
		end else begin
			if (cap_ev) begin
				rx_sh_q   <= rx_sh_d;
				cap_cnt_q <= cap_cnt_d;
			end
			if (launch_ev & (cap_cnt_q < frame_bits)) begin
				tx_sh_q <= {tx_sh_q[DATA_W-2:0], 1'b0};
			end
		end
	end

	// pulse-format slave is framed by the pulse falling, closed by the last bit
	always_ff @(posedge clk_sys_i) begin
		if (rst_i | ~slave | ~is_pulse) begin
			slv_act_q <= 1'b0;
		end else if (s_fss_fall) begin
			slv_act_q <= 1'b1;
		end else if (word_done) begin
			slv_act_q <= 1'b0;
		end
	end

	// idle time counter, counted in half serial periods of the programmed rate
	always_ff @(posedge clk_sys_i) begin
		if (rst_i | rx_empty | ser_edge | (state_q != ssp_pkg::ST_IDLE) | s_active) begin
			to_cnt_q <= 7'h00;
		end else if (tick & (to_cnt_q != 7'(ssp_pkg::TIMEOUT_TICKS))) begin
			to_cnt_q <= to_cnt_q + 7'h01;
		end
	end

	// sticky status; a new event in the clearing cycle wins over the clear
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			ovr_q <= 1'b0;
			to_q  <= 1'b0;
		end else begin
			if (rx_push & rx_full) begin
				ovr_q <= 1'b1;
			end else if (irq_clear_i.overrun) begin
				ovr_q <= 1'b0;
			end
			if (tick & (to_cnt_q == 7'(ssp_pkg::TIMEOUT_TICKS - 1))) begin
				to_q <= 1'b1;
			end else if (irq_clear_i.timeout) begin
				to_q <= 1'b0;
			end
		end
	end

	// raw conditions: tx fifo at or below half, rx fifo at or past half, plus the sticky flags
	always_comb begin
		raw_c            = '0;
		raw_c.tx_service = (tx_count <= CW'(ssp_pkg::HALF_DEPTH));
		raw_c.rx_service = (rx_count >= CW'(ssp_pkg::HALF_DEPTH));
		raw_c.timeout    = to_q;
		raw_c.overrun    = ovr_q;
	end

	// status outputs, all one cycle behind the conditions
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			raw_irq_o    <= '0;
			masked_irq_o <= '0;
			irq_o        <= 1'b0;
			tx_dma_req_o <= 1'b0;
			busy_o       <= 1'b0;
		end else begin
			raw_irq_o    <= raw_c;
			masked_irq_o <= raw_c & irq_mask_i;
			irq_o        <= |(raw_c & irq_mask_i);
			tx_dma_req_o <= cfg_i.enable & tx_empty;
			busy_o       <= (state_q != ssp_pkg::ST_IDLE) | s_active | ~tx_empty;
		end
	end

	// read data register is loaded by the popping read
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			data_rd_data_o <= '0;
		end else if (rx_pop) begin
			data_rd_data_o <= rx_head;
		end
	end

	// pin drive enables; a slave never drives clock or frame select
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			serial_clock_pin_oe_o <= 1'b0;
			frame_select_pin_oe_o <= 1'b0;
			serial_out_pin_oe_o   <= 1'b0;
		end else begin
			serial_clock_pin_oe_o <= master;
			frame_select_pin_oe_o <= master;
			if (master) begin
				// pulse format floats data between frames, others hold it driven
				serial_out_pin_oe_o <= ~is_pulse | (state_q != ssp_pkg::ST_IDLE);
			end else begin
				serial_out_pin_oe_o <= s_active;
			end
		end
	end

	assign serial_clock_pin_o = sclk_q;
	assign frame_select_pin_o = fss_q;
	assign serial_out_pin_o   = tx_sh_q[DATA_W-1];

endmodule

// File: testbench/ssp_props.sv
// status and master spi pin checker for the serial port
`timescale 1ns/1ps
module ssp_props (
	// clock and reset
	input wire logic              clk_sys_i,
	input wire logic              rst_i,
	// controls
	input wire ssp_pkg::ssp_cfg_t cfg_i,
	input wire ssp_pkg::ssp_irq_t irq_mask_i,
	input wire ssp_pkg::ssp_irq_t irq_clear_i,
	// watched outputs
	input wire ssp_pkg::ssp_irq_t raw_irq_o,
	input wire ssp_pkg::ssp_irq_t masked_irq_o,
	input wire logic              irq_o,
	input wire logic              tx_dma_req_o,
	input wire logic              busy_o,
	input wire logic              serial_clock_pin_o,
	input wire logic              frame_select_pin_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	// master spi qualifier
	logic spi_m;
	assign spi_m = cfg_i.enable && cfg_i.master && cfg_i.fmt == ssp_pkg::FMT_SPI;

	a_masked_status: assert property ($stable(irq_mask_i) && $stable(raw_irq_o)
		|-> masked_irq_o == (raw_irq_o & irq_mask_i)) else $error("masked status wrong");
	a_irq_or: assert property ($stable(masked_irq_o)
		|-> irq_o == |masked_irq_o) else $error("interrupt line wrong");
	a_dma_empty: assert property ($past(tx_dma_req_o)
		|-> raw_irq_o.tx_service) else $error("dma request without tx service");
	a_idle_clock: assert property ((spi_m && frame_select_pin_o) [*3]
		|-> serial_clock_pin_o == cfg_i.clock_polarity) else $error("idle clock level");
	a_clock_framed: assert property (spi_m && $changed(serial_clock_pin_o)
		|-> !frame_select_pin_o) else $error("clock toggles outside frame");
	a_busy_frame: assert property (spi_m && !frame_select_pin_o && !$past(frame_select_pin_o)
		|-> busy_o) else $error("frame while not busy");
	a_overrun_sticky: assert property (raw_irq_o.overrun && !irq_clear_i.overrun
		&& !$past(irq_clear_i.overrun) |=> raw_irq_o.overrun) else $error("overrun lost");
	a_overrun_clear: assert property (irq_clear_i.overrun
		|-> ##2 !raw_irq_o.overrun) else $error("overrun not cleared");

	// main scenarios reached
	c_frame: cover property (spi_m && $fell(frame_select_pin_o));
	c_overrun: cover property ($rose(raw_irq_o.overrun));
	c_timeout: cover property ($rose(raw_irq_o.timeout));
endmodule

bind ssp_sync_serial_port ssp_props u_props (
	.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cfg_i(cfg_i), .irq_mask_i(irq_mask_i),
	.irq_clear_i(irq_clear_i), .raw_irq_o(raw_irq_o), .masked_irq_o(masked_irq_o),
	.irq_o(irq_o), .tx_dma_req_o(tx_dma_req_o), .busy_o(busy_o),
	.serial_clock_pin_o(serial_clock_pin_o), .frame_select_pin_o(frame_select_pin_o)
);

// File: testbench/ssp_peer.sv
// echoing spi and command-response slave, mode zero, on the far side of the port
`timescale 1ns/1ps
module ssp_peer (
	// link pins
	input  wire logic        sclk_i,
	input  wire logic        sel_n_i,
	input  wire logic        mosi_i,
	output logic             miso_o,
	// frame length and captured bits
	input  wire logic [4:0]  nbits_i,
	input  wire logic [4:0]  lead_i,
	output logic      [15:0] cap_o
);
	logic [31:0] sh = 32'h0000_0000;
	initial cap_o = 16'h0000;
	// reply is the last nbits_i captured bits left aligned, msb first, after lead_i filler bits
	// command replies wait out the control byte and one turnaround bit
	always @(negedge sel_n_i)
		sh = {16'(cap_o << (16 - nbits_i)), 16'h0000} >> lead_i;
	// capture on the first edge, shift on the second
	always @(posedge sclk_i) if (!sel_n_i) cap_o = {cap_o[14:0], mosi_i};
	always @(negedge sclk_i) if (!sel_n_i) sh = sh << 1;
	// released line inverts its last bit so stale data never matches
	assign miso_o = sel_n_i ? ~sh[31] : sh[31];
endmodule

// File: testbench/ssp_sync_serial_port_tb_top.sv
// self-checking bench: master spi traffic against an echoing peer
`timescale 1ns/1ps
module ssp_sync_serial_port_tb_top;
	logic              clk_sys_i = 1'b0;
	logic              rst_i = 1'b1;
	ssp_pkg::ssp_cfg_t cfg;
	ssp_pkg::ssp_irq_t mask, clr, raw, msk;
	logic              wr = 1'b0, rd = 1'b0, irq, dma, busy;
	logic [15:0]       wdat = 16'h0000, rdat, cap, pm;
	logic              sclk, sclk_oe, fs, fs_oe, sin, sout, sout_oe;
	logic [4:0]        nbits, lead;
	logic [15:0]       wq [0:9];
	logic [15:0]       exq [$];
	int                err_total = 0, samples_checked = 0, cyc = 0;
	// pins seen by both ends; frame line pulled up when released
	wire sclk_w = sclk_oe ? sclk : 1'b0;
	wire fs_w = fs_oe ? fs : 1'b1;

	// 40 MHz clock and hang guard
	always #12.5 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			close_out();
		end
	end

	ssp_sync_serial_port u_dut (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cfg_i(cfg),
		.prescale_divisor_i(8'h02), .serial_clock_rate_i(8'h02),
		.irq_mask_i(mask), .irq_clear_i(clr),
		.data_wr_i(wr), .data_wr_data_i(wdat), .data_rd_i(rd), .data_rd_data_o(rdat),
		.raw_irq_o(raw), .masked_irq_o(msk), .irq_o(irq), .tx_dma_req_o(dma), .busy_o(busy),
		.serial_clock_pin_i(sclk_w), .serial_clock_pin_o(sclk), .serial_clock_pin_oe_o(sclk_oe),
		.frame_select_pin_i(fs_w), .frame_select_pin_o(fs), .frame_select_pin_oe_o(fs_oe),
		.serial_in_pin_i(sin), .serial_out_pin_o(sout), .serial_out_pin_oe_o(sout_oe)
	);
	ssp_peer u_peer (
		.sclk_i(sclk_w), .sel_n_i(fs_w), .mosi_i(sout), .miso_o(sin),
		.nbits_i(nbits), .lead_i(lead), .cap_o(cap)
	);

	task automatic step(int n = 1);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// write held high across words so the strobe never drops and rises at once
	task automatic put(int first, int n);
		wr = 1'b1;
		for (int i = first; i < first + n; i++) begin
			wdat = wq[i];
			step();
		end
		wr = 1'b0;
	endtask
	task automatic get(int n);
		rd = 1'b1;
		repeat (n) begin
			step();
			rd = (n > 1);
			chk("rx word", exq.pop_front(), rdat);
			n--;
		end
		rd = 1'b0;
	endtask
	// a hang here is caught by the cycle ceiling
	task automatic idle();
		step(4);
		while (busy !== 1'b0) step();
	endtask

	task automatic t_reset();
		step(3);
		chk("select idle", 16'h0001, fs);
		chk("clock idle", 16'h0000, sclk);
		chk("dma request", 16'h0001, dma);
		chk("raw status", 16'h0001, raw);
	endtask
	task automatic t_xfer(int n, logic [15:0] w);
		logic [15:0] m;
		m = 16'((32'h1 << n) - 1);
		nbits = 5'(n);
		cfg.size_m1 = 4'(n - 1);
		exq.push_back(pm & m);
		pm = (pm << n) | (w & m);
		wq[0] = w;
		put(0, 1);
		idle();
		chk("peer word", w & m, cap & m);
		get(1);
	endtask
	task automatic t_depth();
		for (int i = 0; i < 10; i++) wq[i] = {8'h3C, 4'(i), 4'h5};
		nbits = 5'h08;
		cfg.size_m1 = 4'h7;
		cfg.enable = 1'b0;
		put(0, 9);
		cfg.enable = 1'b1;
		for (int i = 0; i < 8; i++) begin
			exq.push_back(pm & 16'h00FF);
			pm = (pm << 8) | (wq[i] & 16'h00FF);
		end
		idle();
		put(9, 1);
		idle();
		chk("peer word", wq[9] & 16'h00FF, cap & 16'h00FF);
		pm = (pm << 8) | (wq[9] & 16'h00FF);
		step(250);
		mask = 4'hC;
		step(3);
		chk("raw status", 16'h000F, raw);
		chk("masked status", 16'h000C, msk);
		chk("irq line", 16'h0001, irq);
		get(8);
		clr = 4'hC;
		step();
		clr = 4'h0;
		step(3);
		chk("raw cleared", 16'h0001, raw);
		mask = 4'h1;
		step(3);
		chk("irq line", 16'h0001, irq);
		mask = 4'h0;
		step(3);
		chk("irq masked", 16'h0000, irq);
	endtask
	// command format: control byte out, one turnaround bit, then the reply
	task automatic t_cmd(int n, logic [15:0] w);
		nbits = 5'(n);
		lead = 5'(ssp_pkg::CTRL_BITS + ssp_pkg::CMD_WAIT_BITS);
		cfg.size_m1 = 4'(n - 1);
		cfg.fmt = ssp_pkg::FMT_CMD;
		exq.push_back(pm & 16'((32'h1 << n) - 1));
		wq[0] = w;
		put(0, 1);
		idle();
		chk("peer control", w & 16'h00FF, (cap >> (n + 1)) & 16'h00FF);
		get(1);
		cfg.fmt = ssp_pkg::FMT_SPI;
		lead = 5'h00;
	endtask

	task automatic close_out();
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// reset ten cycles, then the scenarios
	initial begin
		cfg = '{enable: 1'b1, master: 1'b1, fmt: ssp_pkg::FMT_SPI, size_m1: 4'h7,
			clock_polarity: 1'b0, clock_phase: 1'b0};
		mask = 4'h0;
		clr = 4'h0;
		nbits = 5'h08;
		lead = 5'h00;
		pm = 16'h0000;
		step(10);
		rst_i = 1'b0;
		t_reset();
		t_xfer(8, 16'hA5C3);
		t_xfer(4, 16'h0009);
		t_xfer(16, 16'h8E71);
		t_xfer(5, 16'h0016);
		t_depth();
		t_cmd(4, 16'h00B6);
		close_out();
	end
endmodule
